/* bench/sadc_scan_ctrl_props.sv */
`timescale 1ns/1ns
module sadc_scan_ctrl_chk
  import sadc_pkg::*;
#(
  parameter int MAX_LOG2 = SADC_MAX_LOG2,
  parameter int MEM_LOG2 = SADC_MAX_LOG2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        diff_trig_out_p,
  input wire logic        diff_trig_out_n,
  input wire sadc_wr_t    buf_wr,
  input wire logic        irq_req,
  input wire logic [7:0]  irq_vector
);
  localparam int LIM = (MAX_LOG2 < MEM_LOG2) ? MAX_LOG2 : MEM_LOG2;
  logic       wr_w;
  logic [2:0] tm_r;
  logic [1:0] sm_r;
  logic [4:0] bl_r;
  assign wr_w = psel && penable && pwrite;
  // Modes as last written, buffer size as last written clamped to LIM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tm_r <= 3'h0;
      sm_r <= 2'h0;
      bl_r <= 5'h0;
    end else begin
      if (wr_w && paddr == SADC_OFS_CTRL) begin
        tm_r <= pwdata[6:4];
        sm_r <= pwdata[3:2];
      end
      if (wr_w && paddr == SADC_OFS_BUFSZ) begin
        bl_r <= (int'(pwdata[4:0]) > LIM) ? 5'(LIM) : pwdata[4:0];
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_inv; diff_trig_out_n == !diff_trig_out_p; endproperty
  a_inv: assert property (p_inv) else $error("trigger pair not inverse");
  property p_width;
    $rose(diff_trig_out_p) |-> diff_trig_out_p [*8] ##1 diff_trig_out_p ##1 diff_trig_out_p
      ##1 !diff_trig_out_p;
  endproperty
  a_width: assert property (p_width) else $error("trigger out width wrong");
  property p_off; tm_r == SADC_TM_OFF |-> !diff_trig_out_p; endproperty
  a_off: assert property (p_off) else $error("trigger out while disabled");
  property p_local; tm_r inside {SADC_TM_SW, SADC_TM_EXT} |-> !diff_trig_out_p; endproperty
  a_local: assert property (p_local) else $error("trigger out in single board");
  property p_slave; tm_r == SADC_TM_SLAVE |-> !diff_trig_out_p; endproperty
  a_slave: assert property (p_slave) else $error("trigger out in slave mode");
  property p_irq_off; wr_w && paddr == SADC_OFS_IRQV && !pwdata[8] |=> !irq_req; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_vec; wr_w && paddr == SADC_OFS_IRQV |=> irq_vector == $past(pwdata[7:0]); endproperty
  a_vec: assert property (p_vec) else $error("irq vector not loaded");
  property p_gap; sm_r == SADC_SM_CONT && buf_wr.valid |=> !buf_wr.valid [*4]; endproperty
  a_gap: assert property (p_gap) else $error("samples closer than a tick");
  property p_addr; buf_wr.valid |-> (buf_wr.addr >> bl_r) == 22'h0; endproperty
  a_addr: assert property (p_addr) else $error("buffer address beyond size");
endmodule : sadc_scan_ctrl_chk
bind sadc_scan_ctrl sadc_scan_ctrl_chk #(.MAX_LOG2(MAX_LOG2), .MEM_LOG2(MEM_LOG2)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .diff_trig_out_p,
  .diff_trig_out_n, .buf_wr, .irq_req, .irq_vector);

/* bench/sadc_trig_src.sv */
`timescale 1ns/1ns
module sadc_trig_src
  import sadc_pkg::*;
#(
  parameter logic [15:0] ADC_VAL = 16'h1234
) (
  input  wire logic        pclk,
  input  wire logic        go_ext,
  input  wire logic        go_diff,
  output logic             external_trigger_in_n,
  output logic             diff_trig_in_p,
  output logic             diff_trig_in_n,
  output logic [15:0]      adc_data
);
  logic [1:0] ext_r = 2'h0;
  logic [1:0] dif_r = 2'h0;
  // Stretch each request into a three-cycle pulse
  always_ff @(posedge pclk) begin
    ext_r <= go_ext ? 2'h3 : ext_r - 2'(ext_r != 2'h0);
    dif_r <= go_diff ? 2'h3 : dif_r - 2'(dif_r != 2'h0);
  end
  // TTL line idles high, trigger is its falling edge
  assign external_trigger_in_n = (ext_r == 2'h0);
  assign diff_trig_in_p        = (dif_r != 2'h0);
  assign diff_trig_in_n        = (dif_r == 2'h0);
  assign adc_data              = ADC_VAL;
endmodule : sadc_trig_src

/* bench/scanning_adc_scan_trigger_control_test.sv */
`timescale 1ns/1ns
module scanning_adc_scan_trigger_control_test;
  import sadc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, go_ext, go_diff, pready, pslverr;
  logic ext_n, dp, dn, dop, don, irq_req;
  logic [7:0] paddr, irq_vector;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] adc, last_data;
  logic [3:0] mux_chan;
  logic [1:0] rng, flt;
  sadc_wr_t buf_wr;
  int miscompares, total_checks, nsmp, irq_at, hi_cnt, cyc;
  time t0, t1;
  logic [31:0] mode_c [4] = '{32'h04, 32'h44, 32'h34, 32'h54};
  int trig_k [4] = '{0, 1, 0, 2};
  int exp_n [4] = '{0, 8, 8, 8};
  int exp_hi [4] = '{0, 10, 10, 0};
  sadc_scan_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_trigger_in_n(ext_n), .diff_trig_in_p(dp),
    .diff_trig_in_n(dn), .diff_trig_out_p(dop), .diff_trig_out_n(don), .adc_data(adc),
    .mux_chan, .chan_range(rng), .chan_filter(flt), .buf_wr, .irq_req, .irq_vector);
  sadc_trig_src src_u (.pclk, .go_ext, .go_diff, .external_trigger_in_n(ext_n),
    .diff_trig_in_p(dp), .diff_trig_in_n(dn), .adc_data(adc));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Sample, interrupt and trigger-out monitor, plus timeout
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (dop === 1'b1) hi_cnt <= hi_cnt + 1;
    if (irq_req === 1'b1 && irq_at < 0) irq_at <= nsmp + int'(buf_wr.valid === 1'b1);
    if (buf_wr.valid === 1'b1) begin
      nsmp <= nsmp + 1;
      last_data <= buf_wr.data;
      t0 <= t1;
      t1 <= $time;
    end
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, read data left in rd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== v && n < 200);
    chk(32'(rd[b]), 32'(v));
  endtask : poll
  task automatic stat(input logic [3:0] e);
    apb(1'b0, SADC_OFS_STATUS, 32'h0);
    chk(32'(rd[3:0]), 32'(e));
  endtask : stat
  task automatic cfg(input logic [31:0] c);
    apb(1'b1, SADC_OFS_CTRL, c);
    apb(1'b1, SADC_OFS_ABORT, 32'h1);
    poll(SADC_OFS_ABORT, SADC_CMD_BIT, 1'b0);
    poll(SADC_OFS_STATUS, 0, 1'b1);
    nsmp = 0;
    irq_at = -1;
    hi_cnt = 0;
  endtask : cfg
  task automatic fire(input int k);
    if (k == 0) apb(1'b1, SADC_OFS_SWTRIG, 32'h1);
    else begin
      go_ext <= (k == 1);
      go_diff <= (k == 2);
      @(posedge pclk);
      go_ext <= 1'b0;
      go_diff <= 1'b0;
    end
  endtask : fire
  task automatic wait_smp(input int n);
    int k;
    k = 0;
    while (nsmp < n && k < 400) begin
      @(posedge pclk);
      k++;
    end
    repeat (4) @(posedge pclk);
  endtask : wait_smp
  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go_ext, go_diff} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    stat(4'h1);
    apb(1'b1, SADC_OFS_SCANT, 32'h10);
    apb(1'b1, SADC_OFS_BUFSZ, 32'h3);
    apb(1'b1, SADC_OFS_IRQV, 32'h1A5);
    $display("test reset done");
    cfg(32'h17);
    chk(32'(irq_vector), 32'hA5);
    stat(4'h5);
    fire(0);
    stat(4'h9);
    wait_smp(8);
    stat(4'h3);
    chk(nsmp, 8);
    chk(32'(last_data), 32'(16'h1234 ^ SADC_SIGN_FLIP));
    chk(32'(irq_req), 32'h1);
    fire(0);
    wait_smp(9);
    chk(nsmp, 8);
    apb(1'b1, SADC_OFS_CLRFLG, 32'h1);
    stat(4'h0);
    $display("test single done");
    cfg(32'h28);
    fire(1);
    wait_smp(8);
    chk(32'(irq_at inside {4, 5}), 32'h1);
    stat(4'h7);
    chk(32'(last_data), 32'h1234);
    $display("test rearm done");
    for (int i = 0; i < 4; i++) begin
      cfg(mode_c[i]);
      fire(trig_k[i]);
      wait_smp(8);
      chk(nsmp, exp_n[i]);
      chk(hi_cnt, exp_hi[i]);
    end
    $display("test trigger modes done");
    cfg(32'h1C);
    for (int i = 1; i < 4; i++) begin
      fire(0);
      wait_smp(i);
      chk(nsmp, i);
    end
    $display("test advance done");
    apb(1'b1, SADC_OFS_PERIOD, 32'h0001_0001);
    cfg(32'h0);
    wait_smp(10);
    chk(32'(nsmp >= 10), 32'h1);
    chk(32'(t1 - t0), 32'd200);
    apb(1'b1, SADC_OFS_IRQV, 32'h0A5);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq_req), 32'h0);
    chk(32'(pslverr), 32'h0);
    $display("test continuous done");
    apb(1'b1, SADC_OFS_CHCFG, 32'h0000_000B);
    @(posedge pclk);
    chk(32'(mux_chan), 32'h0);
    chk(32'(rng), 32'h3);
    chk(32'(flt), 32'h2);
    $display("test channel settings done");
    final_report();
  end
endmodule : scanning_adc_scan_trigger_control_test

/* inc/sadc_pkg.sv */
package sadc_pkg;

  // Register byte offsets
  localparam logic [7:0] SADC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] SADC_OFS_PERIOD = 8'h04;
  localparam logic [7:0] SADC_OFS_BUFSZ  = 8'h08;
  localparam logic [7:0] SADC_OFS_IRQV   = 8'h0C;
  localparam logic [7:0] SADC_OFS_STATUS = 8'h10;
  localparam logic [7:0] SADC_OFS_CLRFLG = 8'h14;
  localparam logic [7:0] SADC_OFS_ABORT  = 8'h18;
  localparam logic [7:0] SADC_OFS_SWTRIG = 8'h1C;
  localparam logic [7:0] SADC_OFS_SCANT  = 8'h20;
  localparam logic [7:0] SADC_OFS_CHCFG  = 8'h24;
  localparam logic [7:0] SADC_OFS_POS    = 8'h28;
  localparam logic [7:0] SADC_OFS_SAMPLE = 8'h2C;

  // Control, interrupt, command and scan table register fields
  localparam int SADC_CTL_DRDY_END = 0;
  localparam int SADC_CTL_FMT_OFS  = 1;
  localparam int SADC_CTL_SMODE_LO = 2;
  localparam int SADC_CTL_TMODE_LO = 4;
  localparam int SADC_IRQ_EN_BIT   = 8;
  localparam int SADC_CMD_BIT      = 0;
  localparam int SADC_SCANT_LAST   = 4;

  // Timing
  localparam int SADC_TICK_NS  = 50;
  localparam int SADC_CLK_NS   = 10;
  localparam int SADC_TICK_CYC = SADC_TICK_NS / SADC_CLK_NS;
  localparam int SADC_TRIG_OUT_NS  = 100;
  localparam int SADC_TRIG_OUT_CYC = SADC_TRIG_OUT_NS / SADC_CLK_NS;

  // Sizes and the sign-flip mask
  localparam int SADC_NCH        = 16;
  localparam int SADC_SCAN_LEN   = 16;
  localparam int SADC_MAX_LOG2   = 22;
  localparam int SADC_PERIOD_W   = 16;
  localparam int SADC_PRESC_W    = 16;
  localparam logic [15:0] SADC_SIGN_FLIP = 16'h8000;

  typedef enum logic [1:0] {
    SADC_SM_CONT   = 2'h0,
    SADC_SM_SINGLE = 2'h1,
    SADC_SM_REARM  = 2'h2,
    SADC_SM_ADV    = 2'h3
  } sadc_smode_t;

  typedef enum logic [2:0] {
    SADC_TM_OFF      = 3'h0,
    SADC_TM_SW       = 3'h1,
    SADC_TM_EXT      = 3'h2,
    SADC_TM_MST_SW   = 3'h3,
    SADC_TM_MST_EXT  = 3'h4,
    SADC_TM_SLAVE    = 3'h5
  } sadc_tmode_t;

  typedef enum logic [3:0] {
    SADC_ST_CFG  = 4'b0001,
    SADC_ST_ARM  = 4'b0010,
    SADC_ST_RUN  = 4'b0100,
    SADC_ST_DONE = 4'b1000
  } sadc_state_t;

  // Control parameters written by software
  typedef struct packed {
    logic        drdy_end;
    logic        fmt_offset;
    sadc_smode_t smode;
    sadc_tmode_t tmode;
    logic [15:0] period;
    logic [15:0] prescale;
    logic [4:0]  buf_log2;
    logic [7:0]  irq_vector;
    logic        irq_en;
  } sadc_cfg_t;

  // Sample handed to the buffer
  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [21:0] addr;
    logic [15:0] data;
  } sadc_wr_t;

endpackage : sadc_pkg

/* src/sadc_scan_ctrl.sv */
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module sadc_scan_ctrl
  import sadc_pkg::*;
#(
  parameter int MAX_LOG2 = SADC_MAX_LOG2,
  parameter int MEM_LOG2 = SADC_MAX_LOG2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_trigger_in_n,
  input  wire logic        diff_trig_in_p,
  input  wire logic        diff_trig_in_n,
  output logic             diff_trig_out_p,
  output logic             diff_trig_out_n,
  input  wire logic [15:0] adc_data,
  output logic [3:0]       mux_chan,
  output logic [1:0]       chan_range,
  output logic [1:0]       chan_filter,
  output sadc_wr_t         buf_wr,
  output logic             irq_req,
  output logic [7:0]       irq_vector
);

  typedef struct packed {
    sadc_cfg_t   cfg;
    sadc_state_t st;
    logic [SADC_SCAN_LEN-1:0][4:0] tbl;
    logic [SADC_NCH-1:0][3:0]      rng_filt;
    logic        cfg_done;
    logic        drdy;
    logic        armed;
    logic        trig;
    logic        cmd_clr;
    logic        cmd_abort;
    logic        cmd_sw;
    logic        cfg_chg;
    logic [3:0]  tidx;
    logic [21:0] pos;
    logic [15:0] cnt_per;
    logic [15:0] cnt_pre;
    logic [2:0]  cnt_tick;
    logic        ext_q;
    logic        dif_q;
    logic [3:0]  tout;
    logic        adv_go;
    sadc_wr_t    wr;
    logic [31:0] rdata;
  } sadc_regs_t;

  sadc_regs_t s_r;
  sadc_regs_t s_nxt;

  // Clamp buffer exponent to the smaller of MAX_LOG2 and MEM_LOG2
  function automatic logic [4:0] buf_lim(input logic [4:0] req);
    logic [4:0] lim;
    lim = (MAX_LOG2 < MEM_LOG2) ? 5'(MAX_LOG2) : 5'(MEM_LOG2);
    return (req > lim) ? lim : req;
  endfunction : buf_lim

  function automatic logic [21:0] buf_last(input logic [4:0] l2);
    return 22'((23'h1 << l2) - 23'h1);
  endfunction : buf_last

  logic        wr_acc;
  logic        rd_acc;
  logic        trig_ev;
  logic        valid_trig;
  logic        sample_tick;
  logic [21:0] last;
  logic [21:0] mid;
  logic        mode_chg;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign prdata  = s_r.rdata;
  assign diff_trig_out_p = (s_r.tout != 4'h0);
  assign diff_trig_out_n = ~diff_trig_out_p;
  assign irq_vector = s_r.cfg.irq_vector;
  assign buf_wr   = s_r.wr;
  assign mux_chan = s_r.tbl[s_r.tidx][3:0];
  assign chan_range  = s_r.rng_filt[mux_chan][1:0];
  assign chan_filter = s_r.rng_filt[mux_chan][3:2];

  always_comb begin
    s_nxt = s_r;
    mode_chg = 1'b0;
    last = buf_last(buf_lim(s_r.cfg.buf_log2));
    mid  = last >> 1;
    // Command bits self-clear after one cycle of service
    s_nxt.cmd_clr   = 1'b0;
    s_nxt.cmd_abort = 1'b0;
    s_nxt.cmd_sw    = 1'b0;
    s_nxt.cfg_chg   = 1'b0;
    s_nxt.wr.valid  = 1'b0;
    s_nxt.adv_go    = 1'b0;
    if (s_r.tout != 4'h0) begin
      s_nxt.tout = s_r.tout - 4'h1;
    end
    // Register writes
    if (wr_acc) begin
      case (paddr)
        SADC_OFS_CTRL: begin
          s_nxt.cfg.drdy_end   = pwdata[SADC_CTL_DRDY_END];
          s_nxt.cfg.fmt_offset = pwdata[SADC_CTL_FMT_OFS];
          s_nxt.cfg.smode = sadc_smode_t'(pwdata[SADC_CTL_SMODE_LO +: 2]);
          s_nxt.cfg.tmode = sadc_tmode_t'(pwdata[SADC_CTL_TMODE_LO +: 3]);
          mode_chg = 1'b1;
        end
        SADC_OFS_PERIOD: begin
          s_nxt.cfg.period   = pwdata[15:0];
          s_nxt.cfg.prescale = pwdata[31:16];
          mode_chg = 1'b1;
        end
        SADC_OFS_BUFSZ: begin
          s_nxt.cfg.buf_log2 = pwdata[4:0];
          mode_chg = 1'b1;
        end
        SADC_OFS_IRQV: begin
          s_nxt.cfg.irq_vector = pwdata[7:0];
          s_nxt.cfg.irq_en     = pwdata[SADC_IRQ_EN_BIT];
        end
        SADC_OFS_CLRFLG: s_nxt.cmd_clr   = pwdata[SADC_CMD_BIT];
        SADC_OFS_ABORT:  s_nxt.cmd_abort = pwdata[SADC_CMD_BIT];
        SADC_OFS_SWTRIG: s_nxt.cmd_sw    = pwdata[SADC_CMD_BIT];
        SADC_OFS_SCANT: begin
          s_nxt.tbl[pwdata[11:8]] = pwdata[4:0];
          mode_chg = 1'b1;
        end
        SADC_OFS_CHCFG: begin
          s_nxt.rng_filt[pwdata[11:8]] = pwdata[3:0];
          mode_chg = 1'b1;
        end
        default: begin
        end
      endcase
    end
    s_nxt.cfg_chg = mode_chg;
    // Trigger sources by mode
    s_nxt.ext_q = external_trigger_in_n;
    s_nxt.dif_q = diff_trig_in_p & ~diff_trig_in_n;
    case (s_r.cfg.tmode)
      SADC_TM_SW, SADC_TM_MST_SW: trig_ev = s_r.cmd_sw;
      SADC_TM_EXT, SADC_TM_MST_EXT:
        trig_ev = s_r.ext_q & ~external_trigger_in_n;
      SADC_TM_SLAVE: trig_ev = ~s_r.dif_q & diff_trig_in_p & ~diff_trig_in_n;
      default: trig_ev = 1'b0;
    endcase
    valid_trig = trig_ev & s_r.armed & (s_r.cfg.smode != SADC_SM_CONT);
    if (valid_trig && (s_r.cfg.tmode == SADC_TM_MST_SW ||
                       s_r.cfg.tmode == SADC_TM_MST_EXT)) begin
      s_nxt.tout = 4'(SADC_TRIG_OUT_CYC);
    end
    // Sample clock: 50 ns tick, then prescale, then period
    sample_tick = 1'b0;
    if (s_r.st == SADC_ST_RUN) begin
      if (s_r.cnt_tick == 3'(SADC_TICK_CYC - 1)) begin
        s_nxt.cnt_tick = 3'h0;
        if (s_r.cnt_pre == s_r.cfg.prescale) begin
          s_nxt.cnt_pre = 16'h0;
          if (s_r.cnt_per == s_r.cfg.period) begin
            s_nxt.cnt_per = 16'h0;
            sample_tick = 1'b1;
          end else begin
            s_nxt.cnt_per = s_r.cnt_per + 16'h1;
          end
        end else begin
          s_nxt.cnt_pre = s_r.cnt_pre + 16'h1;
        end
      end else begin
        s_nxt.cnt_tick = s_r.cnt_tick + 3'h1;
      end
    end else begin
      s_nxt.cnt_tick = 3'h0;
      s_nxt.cnt_pre  = 16'h0;
      s_nxt.cnt_per  = 16'h0;
    end
    // Scan state machine
    case (s_r.st)
      SADC_ST_CFG: begin
        s_nxt.pos  = 22'h0;
        s_nxt.tidx = 4'h0;
        s_nxt.cfg_done = 1'b1;
        if (s_r.cfg.smode == SADC_SM_CONT) begin
          s_nxt.st = SADC_ST_RUN;
          s_nxt.armed = 1'b0;
        end else begin
          s_nxt.st = SADC_ST_ARM;
          s_nxt.armed = 1'b1;
        end
      end
      SADC_ST_ARM: begin
        if (valid_trig) begin
          s_nxt.armed = 1'b0;
          s_nxt.trig  = 1'b1;
          s_nxt.st    = SADC_ST_RUN;
          s_nxt.adv_go = 1'b1;
          s_nxt.armed = (s_r.cfg.smode == SADC_SM_ADV) ? 1'b0 : 1'b0;
        end
      end
      SADC_ST_RUN: begin
        if (s_r.cfg.smode == SADC_SM_ADV) begin
          // One sample per trigger, then wait for the next
          if (s_r.adv_go) begin
            sample_tick = 1'b1;
          end
        end
        if (sample_tick) begin
          s_nxt.wr.valid = 1'b1;
          s_nxt.wr.chan  = s_r.tbl[s_r.tidx][3:0];
          s_nxt.wr.addr  = s_r.pos;
          s_nxt.wr.data  = s_r.cfg.fmt_offset ? (adc_data ^ SADC_SIGN_FLIP)
                                              : adc_data;
          if (s_r.tbl[s_r.tidx][SADC_SCANT_LAST] ||
              s_r.tidx == 4'(SADC_SCAN_LEN - 1)) begin
            s_nxt.tidx = 4'h0;
          end else begin
            s_nxt.tidx = s_r.tidx + 4'h1;
          end
          if ((s_r.cfg.drdy_end && s_r.pos == last) ||
              (!s_r.cfg.drdy_end && s_r.pos == mid)) begin
            s_nxt.drdy = 1'b1;
          end
          if (s_r.pos == last) begin
            s_nxt.pos = 22'h0;
            case (s_r.cfg.smode)
              SADC_SM_CONT: s_nxt.st = SADC_ST_RUN;
              SADC_SM_SINGLE: begin
                s_nxt.st = SADC_ST_DONE;
                s_nxt.trig = 1'b0;
              end
              default: begin
                s_nxt.st = SADC_ST_ARM;
                s_nxt.armed = 1'b1;
                s_nxt.trig = 1'b0;
              end
            endcase
          end else begin
            s_nxt.pos = s_r.pos + 22'h1;
            if (s_r.cfg.smode == SADC_SM_ADV) begin
              s_nxt.st = SADC_ST_ARM;
              s_nxt.armed = 1'b1;
            end
          end
        end
      end
      SADC_ST_DONE: begin
        // Further triggers ignored until abort or a parameter change
        s_nxt.armed = 1'b0;
      end
      default: s_nxt.st = SADC_ST_CFG;
    endcase
    // Flag clears; a data-ready set in the same cycle wins, cfg_done clears anyway
    if (s_r.cmd_clr || s_r.cmd_abort) begin
      s_nxt.cfg_done = 1'b0;
      if (!(s_nxt.drdy && !s_r.drdy)) begin
        s_nxt.drdy = 1'b0;
      end
    end
    // Abort or parameter change reconfigures
    if (s_r.cmd_abort || s_r.cfg_chg) begin
      s_nxt.st    = SADC_ST_CFG;
      s_nxt.trig  = 1'b0;
      s_nxt.armed = 1'b0;
      if (s_r.cfg_chg) begin
        s_nxt.cfg_done = 1'b0;
      end
    end
    // Register reads
    s_nxt.rdata = 32'h0;
    if (rd_acc) begin
      case (paddr)
        SADC_OFS_CTRL: s_nxt.rdata = {24'h0, 1'b0, s_r.cfg.tmode, s_r.cfg.smode,
                                      s_r.cfg.fmt_offset, s_r.cfg.drdy_end};
        SADC_OFS_PERIOD: s_nxt.rdata = {s_r.cfg.prescale, s_r.cfg.period};
        SADC_OFS_BUFSZ:  s_nxt.rdata = {27'h0, buf_lim(s_r.cfg.buf_log2)};
        SADC_OFS_IRQV:   s_nxt.rdata = {23'h0, s_r.cfg.irq_en, s_r.cfg.irq_vector};
        SADC_OFS_STATUS: s_nxt.rdata = {28'h0, s_r.trig, s_r.armed, s_r.drdy,
                                        s_r.cfg_done};
        SADC_OFS_CLRFLG: s_nxt.rdata = {31'h0, s_r.cmd_clr};
        SADC_OFS_ABORT:  s_nxt.rdata = {31'h0, s_r.cmd_abort | s_r.cfg_chg};
        SADC_OFS_SWTRIG: s_nxt.rdata = {31'h0, s_r.cmd_sw};
        SADC_OFS_POS:    s_nxt.rdata = {10'h0, s_r.pos};
        SADC_OFS_SAMPLE: s_nxt.rdata = {16'h0, s_r.wr.data};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  // Interrupt request follows the data-ready flag when enabled
  assign irq_req = s_r.drdy & s_r.cfg.irq_en;

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= SADC_ST_CFG;
      s_r.ext_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : sadc_scan_ctrl
